/* File: sdram_map_pkg.sv */
package sdram_map_pkg;
    // host address and memory geometry
    localparam int          HOST_ADDR_W      = 27;   // byte address, 128 MB top
    localparam int          MEM_ADDR_W       = 13;   // pins 12..0
    localparam int          DATA_W           = 64;   // every bank is a full 64-bit word
    localparam int          BANK_MAX_SMALL   = 4;    // chip selects with 16 Mbit parts
    localparam int          BANK_MAX_LARGE   = 2;    // chip selects with 64/128 Mbit parts
    localparam int          TOTAL_MB         = 128;
    // host address bit positions
    localparam int          BA_LOW_BIT       = 11;
    localparam int          BA_HIGH_BIT      = 12;
    localparam int          BANK_SEL_LSB     = 25;   // external bank index, 16 Mbit
    localparam int          BANK_SEL_LSB_BIG = 27;   // 64/128 Mbit: one extra bit above
    // synchronous mode saves memory-clock cycles on the first beat of a burst
    localparam logic [3:0]  SYNC_SAVING      = 4'h4;
    localparam logic [3:0]  ASYNC_FIRST_LAT  = 4'h8;
    localparam logic [1:0]  CAS_LATENCY_TWO  = 2'h2;
    // reset values
    localparam logic [7:0]  MCLK_DIV_RST     = 8'h01;
    localparam logic [7:0]  GFX_SIZE_RST     = 8'h00;

    typedef enum logic [1:0] {
        DENS_16M_2B  = 2'h0,
        DENS_BIG_2B  = 2'h1,
        DENS_BIG_4B  = 2'h2
    } density_t;

    typedef enum logic [3:0] {
        ST_IDLE   = 4'h1,
        ST_ACT    = 4'h2,
        ST_WAIT   = 4'h4,
        ST_CMD    = 4'h8
    } phase_t;
endpackage : sdram_map_pkg

/* File: sdram_bank_address_mapper.sv */
`timescale 1ns/1ns
module sdram_bank_address_mapper #(
    parameter int GFX_UNIT_SHIFT = 20   // graphics size counted in 1 MB units
) (
    input  wire logic                                   clk,
    input  wire logic                                   nrst,
    input  wire logic                                   sync_strap,
    input  wire logic                                   core_ratio_two,
    input  wire sdram_map_pkg::density_t                density,
    input  wire logic [7:0]                             gfx_size_mb,
    input  wire logic [7:0]                             mclk_div,
    input  wire logic                                   req_valid,
    input  wire logic                                   req_gfx,
    input  wire logic                                   req_write,
    input  wire logic [sdram_map_pkg::HOST_ADDR_W-1:0]  req_addr,
    output logic                                        req_ready,
    output logic                                        done,
    output logic                                        mclk_en,
    output logic                                        core_clk_en,
    output logic [sdram_map_pkg::MEM_ADDR_W-1:0]        memory_address_pins,
    output logic                                        internal_bank_select_low,
    output logic                                        internal_bank_select_high,
    output logic                                        chip_select_bank_zero_n,
    output logic                                        chip_select_bank_one_n,
    output logic                                        chip_select_bank_two,
    output logic                                        chip_select_bank_three,
    output logic                                        cmd_activate_n,
    output logic                                        cmd_rw_n,
    output logic                                        cmd_write,
    output logic [1:0]                                  cas_latency_two,
    output logic [1:0]                                  max_banks
);
    import sdram_map_pkg::*;

    // strap and mode pins come from the board, so they are synchronised first
    logic     strap_m_q, strap_q;
    logic     ratio_m_q, ratio_q;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            strap_m_q <= 1'b0;
            strap_q   <= 1'b0;
            ratio_m_q <= 1'b0;
            ratio_q   <= 1'b0;
        end else begin
            strap_m_q <= sync_strap;
            strap_q   <= strap_m_q;
            ratio_m_q <= core_ratio_two;
            ratio_q   <= ratio_m_q;
        end
    end

    // strap is latched once after reset; async mode may change rate live
    // wait two edges so the synchroniser holds the pin level, not its reset value
    logic       strap_taken_q;
    logic       sync_mode_q;
    logic [1:0] strap_cnt_q;
    logic [7:0] div_cnt_q, div_cnt_d, div_lim_q;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            strap_taken_q <= 1'b0;
            sync_mode_q   <= 1'b0;
            strap_cnt_q   <= 2'h0;
        end else if (strap_cnt_q != 2'h2) begin
            strap_cnt_q <= strap_cnt_q + 2'h1;
        end else if (!strap_taken_q) begin
            strap_taken_q <= 1'b1;
            sync_mode_q   <= strap_q;
        end
    end

    // divider limit: sync locks to host rate, async follows mclk_div live
    wire  [7:0] div_lim_d  = sync_mode_q ? MCLK_DIV_RST :
                             (mclk_div == 8'h00 ? MCLK_DIV_RST : mclk_div);
    wire        div_wrap   = (div_cnt_q + 8'h01 >= div_lim_q);
    assign      div_cnt_d  = div_wrap ? 8'h00 : div_cnt_q + 8'h01;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            div_cnt_q <= 8'h00;
            div_lim_q <= MCLK_DIV_RST;
        end else begin
            div_lim_q <= div_lim_d;
            div_cnt_q <= div_cnt_d;
        end
    end
    assign mclk_en = div_wrap;

    // core clock enable: every host cycle for x2, every other one for x1
    logic core_tog_q;
    always_ff @(posedge clk) begin
        if (!nrst)
            core_tog_q <= 1'b0;
        else
            core_tog_q <= ~core_tog_q;
    end
    assign core_clk_en = ratio_q | core_tog_q;

    // placement: graphics at bottom of bank 0, host memory directly above
    wire [HOST_ADDR_W-1:0] gfx_top   = HOST_ADDR_W'({gfx_size_mb} << GFX_UNIT_SHIFT);
    wire [HOST_ADDR_W-1:0] phys_addr = req_gfx ? req_addr
                                              : HOST_ADDR_W'(req_addr + gfx_top);
    // bank index above the device capacity; 64-bit words so A2..A0 dropped
    wire [1:0]  bank_small = phys_addr[BANK_SEL_LSB +: 2];
    wire        bank_big   = 1'b0;
    wire        big_part   = (density != DENS_16M_2B);

    // row and column fields per density
    logic [MEM_ADDR_W-1:0] row_f, col_f;
    logic                  ba_lo, ba_hi;
    always_comb begin
        ba_lo = phys_addr[BA_LOW_BIT];
        ba_hi = 1'b0;
        row_f = '0;
        col_f = '0;
        unique case (density)
            DENS_16M_2B: begin
                row_f = {2'b00, phys_addr[22:12]};
                col_f = {2'b00, 1'b0, phys_addr[24:23], phys_addr[10:3]};
            end
            DENS_BIG_2B: begin
                row_f = phys_addr[24:12];
                col_f = {3'b000, phys_addr[26:25], phys_addr[10:3]};
            end
            DENS_BIG_4B: begin
                ba_hi = phys_addr[BA_HIGH_BIT];
                row_f = {1'b0, phys_addr[24:13]};
                col_f = {1'b0, 2'b00, phys_addr[26:25], phys_addr[10:3]};
            end
            default: begin
                row_f = '0;
                col_f = '0;
            end
        endcase
    end

    // command phase machine, leaving idle on a request, then stepping on memory clock enables
    phase_t     st_q, st_d;
    logic [3:0] wait_q;
    logic [MEM_ADDR_W-1:0] row_q, col_q;
    logic       ba_lo_q, ba_hi_q, wr_q, big_q;
    logic [1:0] bank_q;
    wire  [3:0] first_lat = sync_mode_q ? ASYNC_FIRST_LAT - SYNC_SAVING
                                        : ASYNC_FIRST_LAT;
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            ST_IDLE: if (req_valid) st_d = ST_ACT;
            ST_ACT:  if (mclk_en) st_d = ST_WAIT;
            ST_WAIT: if (mclk_en && wait_q == 4'h0) st_d = ST_CMD;
            ST_CMD:  if (mclk_en) st_d = ST_IDLE;
            default: st_d = ST_IDLE;
        endcase
    end
    assign req_ready = (st_q == ST_IDLE);

    // capture fields at request so bank select cannot move between phases
    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_q    <= ST_IDLE;
            wait_q  <= 4'h0;
            row_q   <= '0;
            col_q   <= '0;
            ba_lo_q <= 1'b0;
            ba_hi_q <= 1'b0;
            wr_q    <= 1'b0;
            big_q   <= 1'b0;
            bank_q  <= 2'b00;
        end else begin
            st_q <= st_d;
            if (st_q == ST_IDLE && req_valid) begin
                row_q   <= row_f;
                col_q   <= col_f;
                ba_lo_q <= ba_lo;
                ba_hi_q <= ba_hi;
                wr_q    <= req_write;
                big_q   <= big_part;
                bank_q  <= big_part ? {1'b0, bank_big} : bank_small;
                wait_q  <= first_lat - 4'h2;
            end else if (st_q == ST_WAIT && mclk_en && wait_q != 4'h0) begin
                wait_q <= wait_q - 4'h1;
            end
        end
    end

    // pin drive: row with activate, column with read/write
    wire act_ph  = (st_q == ST_ACT);
    wire cmd_ph  = (st_q == ST_CMD);
    wire busy    = act_ph | cmd_ph;
    wire [MEM_ADDR_W-1:0] ma_sel = cmd_ph ? col_q : row_q;
    wire sel_hi_pin = (density == DENS_BIG_4B) ? ba_hi_q : ma_sel[12];
    always_ff @(posedge clk) begin
        if (!nrst) begin
            memory_address_pins       <= '0;
            internal_bank_select_low  <= 1'b0;
            internal_bank_select_high <= 1'b0;
            chip_select_bank_zero_n   <= 1'b1;
            chip_select_bank_one_n    <= 1'b1;
            chip_select_bank_two      <= 1'b1;
            chip_select_bank_three    <= 1'b1;
            cmd_activate_n            <= 1'b1;
            cmd_rw_n                  <= 1'b1;
            cmd_write                 <= 1'b0;
            done                      <= 1'b0;
        end else begin
            memory_address_pins       <= ma_sel;
            internal_bank_select_low  <= ba_lo_q;
            internal_bank_select_high <= ba_hi_q;
            chip_select_bank_zero_n   <= ~(busy && bank_q == 2'd0);
            chip_select_bank_one_n    <= ~(busy && bank_q == 2'd1);
            // upper selects become address/bank pins on large parts
            chip_select_bank_two   <= big_q ? ma_sel[11]
                                            : ~(busy && bank_q == 2'd2);
            chip_select_bank_three <= big_q ? sel_hi_pin
                                            : ~(busy && bank_q == 2'd3);
            cmd_activate_n <= ~(act_ph && mclk_en);
            cmd_rw_n       <= ~(cmd_ph && mclk_en);
            cmd_write      <= wr_q;
            done           <= cmd_ph && mclk_en;
        end
    end

    // mode register value and bank limit shown to the configuring software
    assign cas_latency_two = CAS_LATENCY_TWO;
    assign max_banks       = big_part ? 2'(BANK_MAX_LARGE - 1) : 2'(BANK_MAX_SMALL - 1);
endmodule : sdram_bank_address_mapper

/* File: sdram_map_monitor.sv */
`timescale 1ns/1ns
// pin-level relations of the mapper; single clock domain
module sdram_map_monitor
    import sdram_map_pkg::*;
(
    input wire logic                  clk,
    input wire logic                  nrst,
    input wire density_t              density,
    input wire logic                  req_ready,
    input wire logic                  done,
    input wire logic [MEM_ADDR_W-1:0] memory_address_pins,
    input wire logic                  internal_bank_select_low,
    input wire logic                  internal_bank_select_high,
    input wire logic                  chip_select_bank_zero_n,
    input wire logic                  chip_select_bank_one_n,
    input wire logic                  chip_select_bank_two,
    input wire logic                  chip_select_bank_three,
    input wire logic                  cmd_activate_n,
    input wire logic                  cmd_rw_n,
    input wire logic [1:0]            cas_latency_two,
    input wire logic [1:0]            max_banks
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    wire logic is_small = (density == DENS_16M_2B);
    property p_col_follows; !cmd_activate_n |-> ##[1:40] !cmd_rw_n; endproperty
    a_col_follows: assert property (p_col_follows) else $error("no column command");
    property p_bank_hold;
        !cmd_activate_n |=> ($stable({internal_bank_select_high, internal_bank_select_low})
            until !cmd_rw_n);
    endproperty
    a_bank_hold: assert property (p_bank_hold) else $error("bank select moved");
    property p_busy; !cmd_activate_n |-> !req_ready; endproperty
    a_busy: assert property (p_busy) else $error("ready while busy");
    property p_banks; !cmd_activate_n |-> max_banks == (is_small ? 2'h3 : 2'h1); endproperty
    a_banks: assert property (p_banks) else $error("bank count wrong");
    property p_cs_small;
        is_small && !cmd_activate_n |-> $onehot({~chip_select_bank_three, ~chip_select_bank_two,
            chip_select_bank_one_n ^ 1'b1, chip_select_bank_zero_n ^ 1'b1});
    endproperty
    a_cs_small: assert property (p_cs_small) else $error("select not one-hot");
    property p_ma11;
        !is_small && !cmd_activate_n |->
            chip_select_bank_two == memory_address_pins[11] && !chip_select_bank_zero_n;
    endproperty
    a_ma11: assert property (p_ma11) else $error("third select not address");
    property p_ba1;
        density == DENS_BIG_4B && !(cmd_activate_n && cmd_rw_n) |->
            chip_select_bank_three == internal_bank_select_high;
    endproperty
    a_ba1: assert property (p_ba1) else $error("fourth select not bank high");
    property p_col_zero;
        density == DENS_BIG_2B && !cmd_rw_n |-> !chip_select_bank_three && !chip_select_bank_two;
    endproperty
    a_col_zero: assert property (p_col_zero) else $error("upper column bits set");
    property p_cas; cas_latency_two == CAS_LATENCY_TWO; endproperty
    a_cas: assert property (p_cas) else $error("latency code wrong");
    property p_done; !cmd_rw_n |-> done ##1 (cmd_rw_n && !done); endproperty
    a_done: assert property (p_done) else $error("done missing");
endmodule : sdram_map_monitor

bind sdram_bank_address_mapper sdram_map_monitor sdram_map_monitor_inst (.clk, .nrst,
    .density, .req_ready, .done, .memory_address_pins, .internal_bank_select_low,
    .internal_bank_select_high, .chip_select_bank_zero_n, .chip_select_bank_one_n,
    .chip_select_bank_two, .chip_select_bank_three, .cmd_activate_n, .cmd_rw_n,
    .cas_latency_two, .max_banks);

/* File: sdram_far_model.sv */
`timescale 1ns/1ns
// memory array side: latches what each command presents; every select is answered,
// so bank 0 is always present
module sdram_far_model (
    input wire logic        clk,
    input wire logic [12:0] pins,
    input wire logic [1:0]  ba,
    input wire logic [3:0]  cs,
    input wire logic        act_n,
    input wire logic        rw_n,
    output logic     [12:0] row_q,
    output logic     [12:0] col_q,
    output logic     [3:0]  cs_q,
    output logic     [1:0]  ba_q,
    output logic            ba_ok_q
);
    // row and selects with activate, column with the command after it
    always_ff @(posedge clk) begin
        if (!act_n) begin
            row_q <= pins;
            cs_q <= cs;
            ba_q <= ba;
        end
        if (!rw_n) begin
            col_q <= pins;
            ba_ok_q <= (ba_q === ba);
        end
    end
endmodule : sdram_far_model

/* File: sdram_bank_address_mapper_test.sv */
`timescale 1ns/1ns
module sdram_bank_address_mapper_test;
    import sdram_map_pkg::*;
    logic clk, nrst, sync_strap, core_ratio_two, req_valid, req_gfx, req_write, req_ready, done;
    logic mclk_en, core_clk_en, ba_lo, ba_hi, cs0_n, cs1_n, cs2, cs3, act_n, rw_n, cmd_write;
    logic ba_ok_q;
    logic [1:0] cas_latency_two, max_banks, ba_q;
    logic [3:0] cs_q;
    logic [7:0] gfx_size_mb, mclk_div;
    logic [12:0] memory_address_pins, row_q, col_q;
    logic [26:0] req_addr;
    density_t density;
    int fails, checks, cyc, lat_a, lat_s;
    logic [26:0] av [4] = '{27'h7FFFFF8, 27'h2AAAAA8, 27'h5555550, 27'h0000000};
    sdram_bank_address_mapper sdram_bank_address_mapper_inst (.clk, .nrst, .sync_strap,
        .core_ratio_two, .density, .gfx_size_mb, .mclk_div, .req_valid, .req_gfx, .req_write,
        .req_addr, .req_ready, .done, .mclk_en, .core_clk_en, .memory_address_pins,
        .internal_bank_select_low(ba_lo), .internal_bank_select_high(ba_hi),
        .chip_select_bank_zero_n(cs0_n), .chip_select_bank_one_n(cs1_n),
        .chip_select_bank_two(cs2), .chip_select_bank_three(cs3), .cmd_activate_n(act_n),
        .cmd_rw_n(rw_n), .cmd_write, .cas_latency_two, .max_banks);
    sdram_far_model sdram_far_model_inst (.clk, .pins(memory_address_pins), .ba({ba_hi, ba_lo}),
        .cs({cs3, cs2, cs1_n, cs0_n}), .act_n, .rw_n, .row_q, .col_q, .cs_q, .ba_q, .ba_ok_q);
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish
    // strap is only looked at shortly after release, so a new strap needs a new reset
    task automatic reset_dut(input logic strap);
        nrst = 1'b0;
        sync_strap = strap;
        repeat (6) @(posedge clk);
        #1 nrst = 1'b1;
        repeat (4) @(posedge clk);
        #1;
    endtask : reset_dut
    // one request, held until taken, then both phases checked at the far side
    task automatic xfer(input density_t d, input logic [26:0] a, output int lat);
        int n;
        logic [12:0] er, ec, m;
        logic [3:0] ecs, mcs;
        logic [26:0] p;
        density = d;
        req_addr = a;
        req_write = a[3];
        req_gfx = a[4];
        // host requests sit above the graphics area, counted in 1 MB units
        p = a[4] ? a : 27'(a + ({19'h00000, gfx_size_mb} << 20));
        req_valid = 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (req_ready !== 1'b1 && n < 50);
        #1 req_valid = 1'b0;
        lat = 0;
        while (rw_n !== 1'b0 && lat < 100) begin
            @(posedge clk);
            #1 lat++;
        end
        @(posedge clk);
        #1;
        case (d)
            DENS_16M_2B: {er, ec, m} = {2'h0, p[22:12], 3'h0, p[24:23], p[10:3], 13'h07FF};
            DENS_BIG_2B: {er, ec, m} = {p[24:12], 3'h0, p[26:25], p[10:3], 13'h1FFF};
            default: {er, ec, m} = {1'b0, p[24:13], 3'h0, p[26:25], p[10:3], 13'h0FFF};
        endcase
        ecs = (d == DENS_16M_2B) ? ~(4'h1 << p[26:25]) : 4'h2;
        mcs = (d == DENS_16M_2B) ? 4'hF : 4'h3;
        check("row", row_q & m, er);
        check("column", col_q & m, ec);
        check("bank", ba_q & {d == DENS_BIG_4B, 1'b1}, {p[12] & (d == DENS_BIG_4B), p[11]});
        check("write flag", cmd_write, a[3]);
        check("selects", cs_q & mcs, ecs);
        check("bank held", ba_ok_q, 1'b1);
    endtask : xfer
    task automatic t_map();
        int lat;
        for (int d = 0; d < 3; d++) begin
            foreach (av[i]) begin
                xfer(density_t'(d), av[i], lat);
                if (d == 0) lat_a = lat;
            end
        end
        $display("address map test done");
    endtask : t_map
    // 24 cycles hold a whole number of periods for every divide used here
    task automatic t_clk(input logic [7:0] div, input int exp);
        int n;
        mclk_div = div;
        repeat (6) @(posedge clk);
        n = 0;
        repeat (24) begin
            @(posedge clk);
            if (mclk_en === 1'b1) n++;
        end
        #1 check("memory clock pulses", n, exp);
    endtask : t_clk
    // core enable rate for each ratio over 24 host cycles
    task automatic t_core(input logic r, input int exp);
        int n;
        core_ratio_two = r;
        repeat (6) @(posedge clk);
        n = 0;
        repeat (24) begin
            @(posedge clk);
            if (core_clk_en === 1'b1) n++;
        end
        #1 check("core clock pulses", n, exp);
    endtask : t_core
    // graphics placed at the bottom, host requests offset above it
    task automatic t_gfx();
        int lat;
        gfx_size_mb = 8'h02;
        xfer(DENS_BIG_2B, 27'h0000000, lat);
        xfer(DENS_BIG_2B, 27'h0000010, lat);
        xfer(DENS_16M_2B, 27'h5555550, lat);
        gfx_size_mb = 8'h00;
        $display("graphics placement test done");
    endtask : t_gfx
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            tally_and_finish();
        end
    end
    initial begin
        {fails, checks, cyc} = '0;
        {nrst, sync_strap, core_ratio_two, req_valid, req_gfx, req_write} = '0;
        {gfx_size_mb, req_addr} = '0;
        mclk_div = 8'h01;
        density = DENS_16M_2B;
        reset_dut(1'b0);
        t_map();
        t_gfx();
        t_clk(8'h01, 24);
        t_clk(8'h03, 8);
        t_clk(8'h00, 24);
        t_clk(8'h04, 6);
        $display("async clock test done");
        reset_dut(1'b1);
        t_core(1'b0, 12);
        t_core(1'b1, 24);
        t_clk(8'h03, 24);
        xfer(DENS_16M_2B, av[3], lat_s);
        check("sync saving", lat_a - lat_s, 4);
        $display("sync mode test done");
        tally_and_finish();
    end
endmodule : sdram_bank_address_mapper_test
